// *** rtl/pvcp_pkg.sv ***
// Purpose: shared constants and types of the parallel video capture port
// Assumes: 32-bit AHB-Lite register access, 16-bit port data bus
// Notes: every offset and field position lives here, with the control, delay and count reset values
package pvcp_pkg;

	// ==========================================================
	// widths
	localparam int DATA_W = 16;
	localparam int WORD_W = 32;
	localparam int CNT_W = 16;
	localparam int ADDR_W = 8;
	localparam int CTRL_W = 6;

	// ==========================================================
	// register byte offsets
	localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_DELAY = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_COUNT = 8'h08;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h0C;
	localparam logic [ADDR_W-1:0] ADDR_DATA = 8'h10;

	// ==========================================================
	// control word fields
	localparam int CTRL_EN = 0;
	localparam int CTRL_EMB = 1;
	localparam int CTRL_EDGE = 2;
	localparam int CTRL_POL = 3;
	localparam int CTRL_PACK = 4;
	localparam int CTRL_WIDE = 5;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h00;
	localparam logic [CNT_W-1:0] DELAY_RESET = 16'h0000;
	localparam logic [CNT_W-1:0] COUNT_RESET = 16'h0000;

	// ==========================================================
	// status fields
	localparam int STAT_VALID = 0;
	localparam int STAT_OVR = 1;
	localparam int STAT_BUSY = 2;

	// ==========================================================
	// embedded preamble codes and status byte bits
	localparam logic [7:0] PRE_ONES = 8'hFF;
	localparam logic [7:0] PRE_ZERO = 8'h00;
	localparam int XY_F = 6;
	localparam int XY_V = 5;
	localparam int XY_H = 4;

	localparam logic [WORD_W-1:0] WORD_ZERO = 32'h0000_0000;

	typedef enum logic [2:0] {
		ST_OFF = 3'b000,
		ST_WAIT_FRAME = 3'b001,
		ST_WAIT_LINE = 3'b010,
		ST_DELAY = 3'b011,
		ST_CAPTURE = 3'b100
	} pvcp_state_e;

endpackage : pvcp_pkg

// *** rtl/pvcp_top.sv ***
// Purpose: parallel video capture port with AHB-Lite register access
// Assumes: port clock supplied by the video source; hclk at 10 MHz
// Notes: capture runs on the port clock, registers on hclk
// Operation
// R1: half-duplex data bus up to sixteen bits
// R2: one clock, three syncs, 8+8 data pins
// R3: packed bytes: earlier sample in low byte
// R4: port clock is input only, source-supplied
// R5: embedded mode starts on start-of-frame preamble
// R6: general mode uses line, frame, field inputs
// R7: edge select: 0 rising, 1 falling
// R8: sync polarity: 0 active high, 1 low
// R9: wait programmed delay after line sync
// R10: capture machine runs on port clock only
// R11: idle until frame then line, field low
// R12: stop when sample count reaches programmed count
// R13: resume at next line sync, skip blanking
// R14: sync detections latched internally
// R15: wide samples each fill one transfer slot
// R16: two 16-bit samples per 32-bit word
// R17: board holds unused field input low
// R18: source gives one datum per clock
// R19: disable or reset returns machine to idle
`timescale 1ns/10ps
module pvcp_top (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic port_clock_input,
	input wire logic [pvcp_pkg::DATA_W-1:0] port_data_in,
	output logic [pvcp_pkg::DATA_W-1:0] port_data_out,
	output logic port_data_oe,
	input wire logic line_sync_input,
	input wire logic frame_sync_input,
	input wire logic field_input
);
	import pvcp_pkg::*;

	function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] r);
		reg_hit = (a == r);
	endfunction : reg_hit

	// ==========================================================
	// bus-side registers
	logic [CTRL_W-1:0] ctrl_q;
	logic [CNT_W-1:0] delay_q;
	logic [CNT_W-1:0] count_q;
	logic [WORD_W-1:0] data_q;
	logic valid_q;
	logic ovr_q;
	logic [1:0] busy_s_q;
	logic wr_q;
	logic [ADDR_W-1:0] wa_q;
	logic [31:0] hrdata_q;
	logic [31:0] rd_d;
	logic acc;
	logic rd_acc;
	logic pop;

	pvcp_xfer_if xif ();

	assign acc = hsel && htrans[1] && hready;
	assign rd_acc = acc && !hwrite;
	assign pop = rd_acc && reg_hit(haddr[ADDR_W-1:0], ADDR_DATA);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q <= 1'b0;
			wa_q <= '0;
		end else begin
			wr_q <= acc && hwrite;
			wa_q <= haddr[ADDR_W-1:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_q <= CTRL_RESET;
			delay_q <= DELAY_RESET;
			count_q <= COUNT_RESET;
		end else if (wr_q) begin
			if (reg_hit(wa_q, ADDR_CTRL)) begin
				ctrl_q <= hwdata[CTRL_W-1:0];
			end
			if (reg_hit(wa_q, ADDR_DELAY)) begin
				delay_q <= hwdata[CNT_W-1:0];
			end
			if (reg_hit(wa_q, ADDR_COUNT)) begin
				count_q <= hwdata[CNT_W-1:0];
			end
		end
	end

	// new word wins over a pop in the same cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			valid_q <= 1'b0;
			data_q <= WORD_ZERO;
		end else if (xif.h_stb) begin
			valid_q <= 1'b1;
			data_q <= xif.h_word;
		end else if (pop) begin
			valid_q <= 1'b0;
		end
	end

	// overrun: sticky, write one to clear, set wins
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ovr_q <= 1'b0;
		end else if (xif.h_ovr || (xif.h_stb && valid_q && !pop)) begin
			ovr_q <= 1'b1;
		end else if (wr_q && reg_hit(wa_q, ADDR_STATUS) && hwdata[STAT_OVR]) begin
			ovr_q <= 1'b0;
		end
	end

	a_valid_on_word: assert property (@(posedge hclk) disable iff (!hresetn)
		xif.h_stb |=> valid_q && (data_q == $past(xif.h_word))) // R16
		else $error("delivered word not held for reading");

	always_comb begin
		rd_d = 32'h0000_0000;
		if (reg_hit(haddr[ADDR_W-1:0], ADDR_CTRL)) begin
			rd_d[CTRL_W-1:0] = ctrl_q;
		end else if (reg_hit(haddr[ADDR_W-1:0], ADDR_DELAY)) begin
			rd_d[CNT_W-1:0] = delay_q;
		end else if (reg_hit(haddr[ADDR_W-1:0], ADDR_COUNT)) begin
			rd_d[CNT_W-1:0] = count_q;
		end else if (reg_hit(haddr[ADDR_W-1:0], ADDR_STATUS)) begin
			rd_d[STAT_VALID] = valid_q;
			rd_d[STAT_OVR] = ovr_q;
			rd_d[STAT_BUSY] = busy_s_q[1];
		end else if (reg_hit(haddr[ADDR_W-1:0], ADDR_DATA)) begin
			rd_d = data_q;
		end
	end

	// zero wait states: read data prepared from the address phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_q <= 32'h0000_0000;
		end else if (rd_acc) begin
			hrdata_q <= rd_d;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			port_data_out <= 16'h0000;
			port_data_oe <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			// receive direction only; driver kept for the half-duplex pins
			port_data_out <= 16'h0000; // R1
			port_data_oe <= 1'b0; // R1
		end
	end

	assign hrdata = hrdata_q;

	a_pins_not_driven: assert property (@(posedge hclk) disable iff (!hresetn)
		!port_data_oe && (port_data_out == 16'h0000)) // R1
		else $error("data pins driven during capture");

	// ==========================================================
	// link clock domain
	logic lclk;
	logic lrst1_q;
	logic lrst_n;
	logic [CTRL_W-1:0] cfg_s1_q;
	logic [CTRL_W-1:0] cfg_s2_q;
	logic en_l;

	assign lclk = port_clock_input; // R4

	always_ff @(posedge lclk or negedge hresetn) begin
		if (!hresetn) begin
			lrst1_q <= 1'b0;
			lrst_n <= 1'b0;
		end else begin
			lrst1_q <= 1'b1;
			lrst_n <= lrst1_q;
		end
	end

	always_ff @(posedge lclk or negedge lrst_n) begin
		if (!lrst_n) begin
			cfg_s1_q <= CTRL_RESET;
			cfg_s2_q <= CTRL_RESET;
		end else begin
			cfg_s1_q <= ctrl_q;
			cfg_s2_q <= cfg_s1_q;
		end
	end

	assign en_l = cfg_s2_q[CTRL_EN];

	// limits are quasi-static: taken only while the port is off
	logic [CNT_W-1:0] dly_l_q;
	logic [CNT_W-1:0] lim_l_q;

	always_ff @(posedge lclk or negedge lrst_n) begin
		if (!lrst_n) begin
			dly_l_q <= DELAY_RESET;
			lim_l_q <= COUNT_RESET;
		end else if (!en_l) begin
			dly_l_q <= delay_q;
			lim_l_q <= count_q;
		end
	end

	// pins sampled on both edges; edge select picks one
	logic [DATA_W-1:0] rd_r_q;
	logic [DATA_W-1:0] rd_f_q;
	logic [2:0] sy_r_q;
	logic [2:0] sy_f_q;
	logic [DATA_W-1:0] smp_data;
	logic [2:0] smp_sync;

	always_ff @(posedge lclk or negedge lrst_n) begin
		if (!lrst_n) begin
			rd_r_q <= 16'h0000;
			sy_r_q <= 3'b000;
		end else begin
			rd_r_q <= port_data_in;
			sy_r_q <= {field_input, frame_sync_input, line_sync_input}; // R6
		end
	end

	always_ff @(negedge lclk or negedge lrst_n) begin
		if (!lrst_n) begin
			rd_f_q <= 16'h0000;
			sy_f_q <= 3'b000;
		end else begin
			rd_f_q <= port_data_in;
			sy_f_q <= {field_input, frame_sync_input, line_sync_input};
		end
	end

	assign smp_data = cfg_s2_q[CTRL_EDGE] ? rd_f_q : rd_r_q; // R7
	assign smp_sync = cfg_s2_q[CTRL_EDGE] ? sy_f_q : sy_r_q; // R7

	// ==========================================================
	// sync detection
	logic line_act;
	logic frame_act;
	logic line_prev_q;
	logic frame_prev_q;
	logic [1:0] pre_q;
	logic line_evt;
	logic frame_evt;
	logic sav;
	logic gp;

	assign gp = !cfg_s2_q[CTRL_EMB];
	assign line_act = smp_sync[0] ^ cfg_s2_q[CTRL_POL]; // R8
	assign frame_act = smp_sync[1] ^ cfg_s2_q[CTRL_POL]; // R8

	always_ff @(posedge lclk or negedge lrst_n) begin
		if (!lrst_n) begin
			line_prev_q <= 1'b0;
			frame_prev_q <= 1'b0;
		end else begin
			line_prev_q <= line_act;
			frame_prev_q <= frame_act;
		end
	end

	// preamble tracker: ones, zero, zero, then status byte
	always_ff @(posedge lclk or negedge lrst_n) begin
		if (!lrst_n) begin
			pre_q <= 2'd0;
		end else if (pre_q == 2'd3) begin
			pre_q <= (smp_data[7:0] == PRE_ONES) ? 2'd1 : 2'd0;
		end else if (smp_data[7:0] == PRE_ONES) begin
			pre_q <= 2'd1;
		end else if (pre_q != 2'd0 && smp_data[7:0] == PRE_ZERO) begin
			pre_q <= pre_q + 2'd1;
		end else begin
			pre_q <= 2'd0;
		end
	end

	assign sav = (pre_q == 2'd3) && !smp_data[XY_H] && !smp_data[XY_V];
	assign line_evt = gp ? (line_act && !line_prev_q && !smp_sync[2]) : sav; // R11 R5
	assign frame_evt = gp ? (frame_act && !frame_prev_q) : (sav && !smp_data[XY_F]); // R5

	// ==========================================================
	// capture state machine
	pvcp_state_e st_q;
	logic [CNT_W-1:0] cnt_q;
	logic frame_seen_q;
	logic take;
	logic last;

	assign take = (st_q == ST_CAPTURE);
	assign last = take && ((cnt_q + 16'd1) >= lim_l_q); // R12

	always_ff @(posedge lclk or negedge lrst_n) begin // R10
		if (!lrst_n) begin
			st_q <= ST_OFF; // R19
			cnt_q <= 16'h0000;
		end else if (!en_l) begin
			st_q <= ST_OFF; // R19
			cnt_q <= 16'h0000;
		end else begin
			case (st_q)
				ST_OFF: begin
					st_q <= ST_WAIT_FRAME;
				end
				ST_WAIT_FRAME: begin
					if (frame_evt && !gp) begin
						// one start code opens the frame and its first line
						cnt_q <= 16'h0000;
						st_q <= (dly_l_q == 16'h0000) ? ST_CAPTURE : ST_DELAY; // R5
					end else if (frame_evt) begin
						st_q <= ST_WAIT_LINE; // R11
					end
				end
				ST_WAIT_LINE: begin
					if (line_evt && frame_seen_q) begin
						cnt_q <= 16'h0000;
						st_q <= (dly_l_q == 16'h0000) ? ST_CAPTURE : ST_DELAY; // R9
					end
				end
				ST_DELAY: begin
					if (cnt_q + 16'd1 >= dly_l_q) begin
						cnt_q <= 16'h0000;
						st_q <= ST_CAPTURE; // R9
					end else begin
						cnt_q <= cnt_q + 16'd1;
					end
				end
				ST_CAPTURE: begin
					if (last) begin
						cnt_q <= 16'h0000;
						st_q <= ST_WAIT_LINE; // R13
					end else begin
						cnt_q <= cnt_q + 16'd1;
					end
				end
				default: begin
					st_q <= ST_OFF;
					cnt_q <= 16'h0000;
				end
			endcase
		end
	end

	// frame detection held so syncs may drop during the line
	always_ff @(posedge lclk or negedge lrst_n) begin
		if (!lrst_n) begin
			frame_seen_q <= 1'b0;
		end else if (!en_l) begin
			frame_seen_q <= 1'b0; // R19
		end else if (frame_evt && st_q == ST_WAIT_FRAME) begin
			frame_seen_q <= 1'b1; // R14
		end
	end

	a_idle_till_frame: assert property (@(posedge lclk) disable iff (!lrst_n)
		(st_q == ST_WAIT_FRAME) && !frame_evt |=> (st_q != ST_CAPTURE) && (st_q != ST_DELAY)) // R11
		else $error("capture began without frame sync");
	a_delay_ends: assert property (@(posedge lclk) disable iff (!lrst_n)
		en_l && (st_q == ST_DELAY) && (cnt_q + 16'd1 >= dly_l_q) |=> (st_q == ST_CAPTURE)) // R9
		else $error("delay did not end on programmed count");
	a_delay_bound: assert property (@(posedge lclk) disable iff (!lrst_n)
		(st_q == ST_DELAY) |-> (cnt_q < dly_l_q)) // R9
		else $error("delay counter overran programmed delay");
	a_count_stop: assert property (@(posedge lclk) disable iff (!lrst_n)
		en_l && last ##1 en_l |-> (st_q == ST_WAIT_LINE) && (cnt_q == 16'h0000)) // R12 R13
		else $error("line did not stop at sample count");
	a_frame_latch: assert property (@(posedge lclk) disable iff (!lrst_n)
		$rose(frame_seen_q) |-> $past(frame_evt) && $past(en_l)) // R14
		else $error("frame latched without a frame sync");
	a_disable_idle: assert property (@(posedge lclk) disable iff (!lrst_n)
		!en_l |=> (st_q == ST_OFF) && (cnt_q == 16'h0000) && !frame_seen_q) // R19
		else $error("disable did not return machine to idle");

	// ==========================================================
	// sample packing
	logic [WORD_W-1:0] word_q;
	logic [WORD_W-1:0] word_n;
	logic [1:0] slot_q;
	logic [1:0] slot_n;
	logic byte_pack;
	logic send_q;
	logic [WORD_W-1:0] out_q;

	assign byte_pack = !cfg_s2_q[CTRL_WIDE] && cfg_s2_q[CTRL_PACK];

	always_comb begin
		word_n = word_q;
		if (byte_pack) begin
			word_n[{slot_q, 3'b000} +: 8] = smp_data[7:0]; // R3
			slot_n = slot_q + 2'd1;
		end else begin
			if (cfg_s2_q[CTRL_WIDE]) begin
				word_n[{slot_q[1], 4'h0} +: 16] = smp_data; // R15 R2
			end else begin
				word_n[{slot_q[1], 4'h0} +: 16] = {8'h00, smp_data[7:0]};
			end
			slot_n = slot_q + 2'd2; // R16
		end
	end

	// a short last word of a line is flushed with zero fill
	always_ff @(posedge lclk or negedge lrst_n) begin
		if (!lrst_n) begin
			word_q <= WORD_ZERO;
			slot_q <= 2'd0;
			send_q <= 1'b0;
			out_q <= WORD_ZERO;
		end else if (!en_l) begin
			word_q <= WORD_ZERO;
			slot_q <= 2'd0;
			send_q <= 1'b0;
		end else begin
			send_q <= 1'b0;
			if (take) begin
				if (slot_n == 2'd0 || last) begin
					out_q <= word_n; // R16
					send_q <= 1'b1;
					word_q <= WORD_ZERO;
					slot_q <= 2'd0;
				end else begin
					word_q <= word_n;
					slot_q <= slot_n;
				end
			end
		end
	end

	assign xif.l_word = out_q;
	assign xif.l_send = send_q;

	a_pack_low_first: assert property (@(posedge lclk) disable iff (!lrst_n)
		en_l && take && byte_pack && (slot_q == 2'd0) && !last ##1 en_l
		|-> word_q[7:0] == $past(smp_data[7:0])) // R3
		else $error("earlier byte not in low lane");

	// busy level back to the bus side
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			busy_s_q <= 2'b00;
		end else begin
			busy_s_q <= {busy_s_q[0], (st_q != ST_OFF)};
		end
	end

	pvcp_xfer u_xfer (
		.hclk(hclk),
		.hresetn(hresetn),
		.lclk(lclk),
		.lrst_n(lrst_n),
		.x(xif.xfer)
	);

endmodule : pvcp_top

// *** rtl/pvcp_xfer.sv ***
// Purpose: toggle handshake moving one word at a time across clock domains
// Assumes: hold register stays stable while a request is outstanding
// Notes: a word offered while busy is dropped and flagged as overrun
`timescale 1ns/10ps
module pvcp_xfer (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic lclk,
	input wire logic lrst_n,
	pvcp_xfer_if.xfer x
);
	import pvcp_pkg::*;

	// ==========================================================
	// link side
	logic req_q;
	logic ovr_q;
	logic [WORD_W-1:0] hold_q;
	logic ack_s1_q;
	logic ack_s2_q;
	logic busy;
	logic ack_q;

	assign busy = req_q ^ ack_s2_q;

	always_ff @(posedge lclk or negedge lrst_n) begin
		if (!lrst_n) begin
			req_q <= 1'b0;
			ovr_q <= 1'b0;
			hold_q <= WORD_ZERO;
		end else if (x.l_send) begin
			if (!busy) begin
				hold_q <= x.l_word;
				req_q <= ~req_q;
			end else begin
				ovr_q <= ~ovr_q;
			end
		end
	end

	always_ff @(posedge lclk or negedge lrst_n) begin
		if (!lrst_n) begin
			ack_s1_q <= 1'b0;
			ack_s2_q <= 1'b0;
		end else begin
			ack_s1_q <= ack_q;
			ack_s2_q <= ack_s1_q;
		end
	end

	a_hold_stable: assert property (@(posedge lclk) disable iff (!lrst_n)
		busy |=> (hold_q == $past(hold_q)) || !$past(busy)) // R15
		else $error("word changed while crossing");

	// ==========================================================
	// bus side
	logic [2:0] req_h_q;
	logic [2:0] ovr_h_q;
	logic [WORD_W-1:0] word_h_q;
	logic stb_q;
	logic ovr_stb_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			req_h_q <= 3'b000;
			ovr_h_q <= 3'b000;
			ack_q <= 1'b0;
			stb_q <= 1'b0;
			ovr_stb_q <= 1'b0;
			word_h_q <= WORD_ZERO;
		end else begin
			req_h_q <= {req_h_q[1:0], req_q};
			ovr_h_q <= {ovr_h_q[1:0], ovr_q};
			ack_q <= req_h_q[2];
			stb_q <= req_h_q[1] ^ req_h_q[2];
			ovr_stb_q <= ovr_h_q[1] ^ ovr_h_q[2];
			if (req_h_q[1] ^ req_h_q[2]) begin
				word_h_q <= hold_q;
			end
		end
	end

	assign x.h_word = word_h_q;
	assign x.h_stb = stb_q;
	assign x.h_ovr = ovr_stb_q;

endmodule : pvcp_xfer

// *** rtl/pvcp_xfer_if.sv ***
// Purpose: carries finished capture words from the link domain to the bus domain
// Assumes: l_send is a one-cycle pulse on the port clock
// Notes: h_stb and h_ovr are one-cycle pulses on hclk
`timescale 1ns/10ps
interface pvcp_xfer_if;
	logic [31:0] l_word;
	logic l_send;
	logic [31:0] h_word;
	logic h_stb;
	logic h_ovr;
	modport src (output l_word, output l_send, input h_word, input h_stb, input h_ovr);
	modport xfer (input l_word, input l_send, output h_word, output h_stb, output h_ovr);
endinterface : pvcp_xfer_if

// *** testbench/pvcp_src.sv ***
// Purpose: video source model driving the capture port pins
// Assumes: one datum per port clock; syncs change only between clock edges
// Notes: clock stands still between calls; off-line data is a moving pattern
`timescale 1ns/10ps
module pvcp_src (
	output logic port_clk,
	output logic [15:0] pix,
	output logic lsync,
	output logic fsync,
	output logic field
);
	logic pol;
	logic fall;
	logic [15:0] junk;

	initial begin
		port_clk = 1'b0;
		pix = 16'h0000;
		lsync = 1'b0;
		fsync = 1'b0;
		field = 1'b0;
		pol = 1'b0;
		fall = 1'b0;
		junk = 16'h5A3C;
	end

	// ==========================================================
	// one port clock period
	// data stands only at the agreed edge; the other edge sees its inverse
	task automatic cyc(input logic [15:0] d, input logic ls, input logic fs);
		lsync = ls ^ pol;
		fsync = fs ^ pol;
		pix = fall ? ~d : d;
		#40 port_clk = 1'b1;
		#40 pix = fall ? d : ~d;
		#40 port_clk = 1'b0;
		#40;
	endtask : cyc

	task automatic blank(input int n);
		repeat (n) begin
			junk = junk * 16'h0005 + 16'h3B1D;
			cyc(junk, 1'b0, 1'b0);
		end
	endtask : blank

	// ==========================================================
	// framing
	// frame sync drops before the line starts
	task automatic frame();
		cyc(junk, 1'b0, 1'b1);
		blank(2);
	endtask : frame

	task automatic line(input int n, input logic [15:0] base);
		for (int i = 0; i < n; i++) begin
			cyc(base + 16'(i), 1'b1, 1'b0);
		end
		blank(3);
	endtask : line

	task automatic pre(input logic [7:0] xy);
		cyc(16'h00FF, 1'b0, 1'b0);
		cyc(16'h0000, 1'b0, 1'b0);
		cyc(16'h0000, 1'b0, 1'b0);
		cyc({8'h00, xy}, 1'b0, 1'b0);
	endtask : pre
endmodule : pvcp_src

// *** testbench/testbench.sv ***
// Purpose: self-checking bench for the video capture port
// Assumes: zero-wait register slave; source model on the port pins
// Notes: one word crosses at a time, so each word is read before the next line, except in the overrun check of sc_off
`timescale 1ns/10ps
module testbench;
	import pvcp_pkg::*;
	logic hclk;
	logic hresetn;
	logic hsel;
	logic [31:0] haddr;
	logic [1:0] htrans;
	logic hwrite;
	logic [2:0] hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic pclk;
	logic [DATA_W-1:0] pix;
	logic [DATA_W-1:0] pdo;
	logic poe;
	logic lsync;
	logic fsync;
	logic field;
	int bad_count;
	int samples_checked;
	logic [31:0] rd;

	pvcp_top i_pvcp_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .port_clock_input(pclk),
		.port_data_in(pix), .port_data_out(pdo), .port_data_oe(poe),
		.line_sync_input(lsync), .frame_sync_input(fsync), .field_input(field));

	pvcp_src src (.port_clk(pclk), .pix(pix), .lsync(lsync), .fsync(fsync), .field(field));

	always #50 hclk = ~hclk;

	// ==========================================================
	// reporting
	task automatic end_sim();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : end_sim

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// ==========================================================
	// bus master
	task automatic wait_ready();
		int n;
		n = 0;
		@(posedge hclk);
		while (hreadyout !== 1'b1) begin
			n++;
			if (n > 20) begin
				check("hready", {31'h0, hreadyout}, 32'h0000_0001);
				end_sim();
			end
			@(posedge hclk);
		end
	endtask : wait_ready

	task automatic ahb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd,
		output logic [31:0] r);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h000000, a};
		hwrite <= wr;
		hsize <= 3'b010;
		wait_ready();
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= wd;
		wait_ready();
		r = hrdata;
		check("hresp", {31'h0, hresp}, WORD_ZERO);
	endtask : ahb

	// ==========================================================
	// capture helpers
	// disable first so delay and count load, and let the port clock see it
	task automatic setup(input logic [5:0] c, input logic [15:0] d, input logic [15:0] n);
		ahb(1'b1, ADDR_CTRL, WORD_ZERO, rd);
		src.blank(3);
		ahb(1'b1, ADDR_DELAY, {16'h0000, d}, rd);
		ahb(1'b1, ADDR_COUNT, {16'h0000, n}, rd);
		ahb(1'b1, ADDR_CTRL, {26'h0000000, c}, rd);
		src.blank(4);
	endtask : setup

	task automatic no_word();
		ahb(1'b0, ADDR_STATUS, WORD_ZERO, rd);
		check("idle valid", {31'h0, rd[STAT_VALID]}, WORD_ZERO);
		check("enabled", {31'h0, rd[STAT_BUSY]}, 32'h0000_0001);
	endtask : no_word

	task automatic expect_word(input logic [31:0] exp, input string what);
		int n;
		n = 0;
		do begin
			ahb(1'b0, ADDR_STATUS, WORD_ZERO, rd);
			n++;
		end while (rd[STAT_VALID] !== 1'b1 && n < 30);
		check({what, " valid"}, {31'h0, rd[STAT_VALID]}, 32'h0000_0001);
		if (rd[STAT_VALID] !== 1'b1) begin
			end_sim();
		end
		ahb(1'b0, ADDR_DATA, WORD_ZERO, rd);
		check(what, rd, exp);
		ahb(1'b0, ADDR_STATUS, WORD_ZERO, rd);
		check({what, " consumed"}, {31'h0, rd[STAT_VALID]}, WORD_ZERO);
	endtask : expect_word

	// ==========================================================
	// scenarios
	task automatic sc_regs();
		ahb(1'b1, 8'h14, 32'hFFFF_FFFF, rd);
		for (int i = 0; i < 6; i++) begin
			ahb(1'b0, 8'(4 * i), WORD_ZERO, rd);
			check("reset value", rd, WORD_ZERO);
		end
		ahb(1'b1, ADDR_DELAY, 32'hFFFF_BEEF, rd);
		ahb(1'b1, ADDR_COUNT, 32'h1234_5678, rd);
		ahb(1'b1, ADDR_CTRL, 32'hFFFF_FFFE, rd);
		ahb(1'b0, ADDR_CTRL, WORD_ZERO, rd);
		check("control", rd, 32'h0000_003E);
		ahb(1'b0, ADDR_DELAY, WORD_ZERO, rd);
		check("delay", rd, 32'h0000_BEEF);
		ahb(1'b0, ADDR_COUNT, WORD_ZERO, rd);
		check("count", rd, 32'h0000_5678);
	endtask : sc_regs

	task automatic sc_gp();
		setup(6'h21, 16'h0000, 16'h0002);
		src.line(4, 16'h1000);
		no_word();
		src.frame();
		src.field = 1'b1;
		src.line(4, 16'h1100);
		src.field = 1'b0;
		no_word();
		src.line(4, 16'h2000);
		expect_word(32'h2002_2001, "wide pair");
	endtask : sc_gp

	task automatic sc_pack();
		setup(6'h11, 16'h0003, 16'h0004);
		src.frame();
		src.line(10, 16'hA940);
		expect_word(32'h4746_4544, "packed bytes");
		src.line(10, 16'hB960);
		expect_word(32'h6766_6564, "next line");
	endtask : sc_pack

	task automatic sc_edge();
		src.fall = 1'b1;
		src.pol = 1'b1;
		setup(6'h2D, 16'h0001, 16'h0002);
		src.frame();
		src.line(5, 16'h3000);
		expect_word(32'h3003_3002, "falling low syncs");
		src.fall = 1'b0;
		src.pol = 1'b0;
	endtask : sc_edge

	task automatic sc_emb();
		setup(6'h03, 16'h0000, 16'h0002);
		src.pre(8'hA0);
		src.blank(2);
		src.pre(8'h80);
		src.cyc(16'hC311, 1'b0, 1'b0);
		src.cyc(16'hC322, 1'b0, 1'b0);
		src.blank(3);
		expect_word(32'h0022_0011, "embedded");
	endtask : sc_emb

	// a frame seen before a disable must be forgotten
	task automatic sc_off();
		setup(6'h21, 16'h0000, 16'h0002);
		src.frame();
		ahb(1'b1, ADDR_CTRL, WORD_ZERO, rd);
		src.blank(3);
		ahb(1'b1, ADDR_CTRL, 32'h0000_0021, rd);
		src.blank(4);
		src.line(4, 16'h4000);
		no_word();
		src.frame();
		src.line(4, 16'h5000);
		expect_word(32'h5002_5001, "after restart");
		check("data oe", {31'h0, poe}, WORD_ZERO);
		check("data out", {16'h0000, pdo}, WORD_ZERO);
		// second word lands on an unread first one
		src.line(4, 16'h6000);
		src.line(4, 16'h7000);
		src.blank(2);
		expect_word(32'h7002_7001, "newest word");
		ahb(1'b0, ADDR_STATUS, WORD_ZERO, rd);
		check("overrun set", {31'h0, rd[STAT_OVR]}, 32'h0000_0001);
		ahb(1'b1, ADDR_STATUS, 32'h0000_0002, rd);
		ahb(1'b0, ADDR_STATUS, WORD_ZERO, rd);
		check("overrun cleared", {31'h0, rd[STAT_OVR]}, WORD_ZERO);
	endtask : sc_off

	// reset in mid-run clears registers; link side restarts cleanly
	task automatic sc_reset();
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		ahb(1'b0, ADDR_CTRL, WORD_ZERO, rd);
		check("ctrl after reset", rd, WORD_ZERO);
		ahb(1'b0, ADDR_STATUS, WORD_ZERO, rd);
		check("status after reset", rd, WORD_ZERO);
		setup(6'h21, 16'h0000, 16'h0002);
		src.frame();
		src.line(4, 16'h8000);
		expect_word(32'h8002_8001, "after reset");
	endtask : sc_reset

	initial begin
		hclk = 1'b0;
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0000_0000;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0000_0000;
		bad_count = 0;
		samples_checked = 0;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		src.blank(6);
		sc_regs();
		sc_gp();
		sc_pack();
		sc_edge();
		sc_emb();
		sc_off();
		sc_reset();
		end_sim();
	end
endmodule : testbench
